// ---- design/word_xlat.sv ----
// Purpose: User word translator: defines, executes, lists, saves and purges user words.
// Assumes: Tokens and device clear come from logic on mclk_i; output is drained by the command parser.
// Notes: Saved copy survives reset_n_i; only nvm_erase_n_i blanks it.
`timescale 1ns/1ns
`default_nettype none
module word_xlat (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic nvm_erase_n_i,
  input wire logic dev_clear_i,
  input wire logic tok_valid_i,
  input wire word_xlat_pkg::tok_t tok_i,
  output logic tok_ready_o,
  output logic out_valid_o,
  output word_xlat_pkg::out_t out_o,
  input wire logic out_ready_i,
  output logic err_o,
  output word_xlat_pkg::err_code_t err_code_o,
  output logic mode_new_o
);

  function automatic logic [3:0] find_word(input word_xlat_pkg::entry_t tbl [word_xlat_pkg::NUM_WORDS],
                                           input word_xlat_pkg::count_t n,
                                           input logic [word_xlat_pkg::KEY_W-1:0] key);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < word_xlat_pkg::NUM_WORDS; i++)
    begin
      if ((word_xlat_pkg::count_t'(i) < n) && (tbl[i].key == key))
        res = {1'b1, word_xlat_pkg::word_idx_t'(i)};
    end
    return res;
  endfunction : find_word

  function automatic logic [7:0] opt_char(input logic [7:0] opt);
    return word_xlat_pkg::ASCII_ZERO + opt;
  endfunction : opt_char

  logic [1:0] rst_pipe;
  logic rst_n;
  word_xlat_pkg::state_t state;
  word_xlat_pkg::def_phase_t def_phase;
  logic mode_new;
  word_xlat_pkg::count_t nwords;
  word_xlat_pkg::def_ptr_t def_wr;
  word_xlat_pkg::def_ptr_t def_start;
  logic [word_xlat_pkg::KEY_W-1:0] def_key;
  word_xlat_pkg::word_idx_t cand;
  logic [7:0] opt_val;
  logic opt_used;
  word_xlat_pkg::sp_t sp;
  word_xlat_pkg::count_t list_idx;
  word_xlat_pkg::def_ptr_t cp_cnt;
  logic clear_pend;
  logic out_valid;
  word_xlat_pkg::out_t out_data;
  logic err;
  word_xlat_pkg::err_code_t err_code;

  word_xlat_pkg::entry_t table_mem [word_xlat_pkg::NUM_WORDS];
  word_xlat_pkg::elem_t def_mem [word_xlat_pkg::DEF_DEPTH];
  word_xlat_pkg::entry_t nvm_table [word_xlat_pkg::NUM_WORDS];
  word_xlat_pkg::elem_t nvm_def [word_xlat_pkg::DEF_DEPTH];
  word_xlat_pkg::count_t nvm_nwords;
  word_xlat_pkg::def_ptr_t nvm_def_wr;
  logic nvm_mode;
  word_xlat_pkg::def_ptr_t stack_ptr [word_xlat_pkg::STACK_DEPTH];
  word_xlat_pkg::def_ptr_t stack_end [word_xlat_pkg::STACK_DEPTH];

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  wire logic stall = out_valid && !out_ready_i;
  wire logic is_number = tok_i.kind == word_xlat_pkg::TK_NUMBER;
  assign tok_ready_o = !stall && ((state == word_xlat_pkg::S_IDLE) ||
                                  ((state == word_xlat_pkg::S_WAIT_OPT) && is_number));
  wire logic tok_fire = tok_valid_i && tok_ready_o;
  wire logic idle_fire = tok_fire && (state == word_xlat_pkg::S_IDLE);
  wire logic plain_tok = idle_fire && (def_phase == word_xlat_pkg::D_NONE);
  wire logic name_tok = idle_fire && (def_phase == word_xlat_pkg::D_NAME) &&
                        (tok_i.kind == word_xlat_pkg::TK_NAME);
  wire logic body_tok = idle_fire && (def_phase == word_xlat_pkg::D_BODY);
  wire logic ref_tok = idle_fire && (def_phase == word_xlat_pkg::D_REF);
  wire logic [3:0] lookup = find_word(table_mem, nwords, tok_i.key);
  wire logic hit = lookup[3];
  wire logic mem_full = def_wr == word_xlat_pkg::DEF_FULL;
  wire logic name_long = tok_i.len > 6'(word_xlat_pkg::MAX_NAME_LEN);
  wire logic [7:0] tok_char = tok_i.value;

  // Literal characters are kept as typed, wild-card marks as a mark with no character, references as an index
  wire logic store_lit = body_tok && !mem_full &&
                         ((tok_i.kind == word_xlat_pkg::TK_NATIVE) || (tok_i.kind == word_xlat_pkg::TK_WILD)); // R11
  wire logic store_ref = ref_tok && !mem_full && hit && (tok_i.kind == word_xlat_pkg::TK_NAME); // R07 R23
  wire logic store_elem = store_lit || store_ref;
  wire word_xlat_pkg::elem_t new_elem = store_ref ? {word_xlat_pkg::EL_REF, 5'h00, lookup[2:0]} :
                                        (tok_i.kind == word_xlat_pkg::TK_WILD) ?
                                        {word_xlat_pkg::EL_WILD, word_xlat_pkg::OPTION_NONE} :
                                        {word_xlat_pkg::EL_LIT, tok_char};
  wire logic commit = body_tok && (tok_i.kind == word_xlat_pkg::TK_SEMI);
  wire word_xlat_pkg::entry_t new_entry = {def_key, def_start, def_wr};

  wire logic clear_req = dev_clear_i || clear_pend;
  wire logic clear_take = clear_req && (state != word_xlat_pkg::S_SAVE);
  wire logic copy_last = cp_cnt == word_xlat_pkg::COPY_LAST;
  wire logic restoring = state == word_xlat_pkg::S_RESTORE;
  wire logic saving = state == word_xlat_pkg::S_SAVE;

  // Execution walks a small stack of frames so references expand only when run
  wire word_xlat_pkg::stack_idx_t top = word_xlat_pkg::stack_idx_t'(sp - 3'h1);
  wire word_xlat_pkg::def_ptr_t cur_ptr = stack_ptr[top];
  wire logic frame_done = cur_ptr == stack_end[top];
  wire word_xlat_pkg::elem_t cur_elem = def_mem[cur_ptr[5:0]];
  wire word_xlat_pkg::entry_t ref_entry = table_mem[cur_elem.data[2:0]];
  wire word_xlat_pkg::entry_t cand_entry = table_mem[cand];
  wire logic start_exec = (state == word_xlat_pkg::S_WAIT_OPT) && tok_valid_i && !stall && !clear_take;
  wire logic exec_step = (state == word_xlat_pkg::S_EXEC) && !stall && !clear_take;
  wire logic elem_step = exec_step && !frame_done;
  wire logic is_ref = cur_elem.kind == word_xlat_pkg::EL_REF;
  wire logic push = elem_step && is_ref && (sp < word_xlat_pkg::STACK_FULL);
  wire logic first_wild = elem_step && (cur_elem.kind == word_xlat_pkg::EL_WILD) && !opt_used;
  wire logic later_wild = elem_step && (cur_elem.kind == word_xlat_pkg::EL_WILD) && opt_used;
  wire logic list_step = (state == word_xlat_pkg::S_LIST) && !stall && !clear_take;
  wire logic [word_xlat_pkg::KEY_W-1:0] newest_key = table_mem[3'(list_idx - 4'h1)].key;

  always_ff @(posedge mclk_i)
  begin
    if (store_elem)
      def_mem[def_wr[5:0]] <= new_elem;
    else if (restoring)
      def_mem[cp_cnt[5:0]] <= nvm_def[cp_cnt[5:0]];
    if (commit)
      table_mem[nwords[2:0]] <= new_entry;
    else if (restoring && (cp_cnt < 7'(word_xlat_pkg::NUM_WORDS)))
      table_mem[cp_cnt[2:0]] <= nvm_table[cp_cnt[2:0]];
  end

  // Saved copy has no power-on reset on purpose: it must outlive resets
  always_ff @(posedge mclk_i)
  begin
    if (saving)
    begin
      nvm_def[cp_cnt[5:0]] <= def_mem[cp_cnt[5:0]]; // R13
      if (cp_cnt < 7'(word_xlat_pkg::NUM_WORDS))
        nvm_table[cp_cnt[2:0]] <= table_mem[cp_cnt[2:0]]; // R13
    end
  end

  always_ff @(posedge mclk_i or negedge nvm_erase_n_i)
  begin
    if (!nvm_erase_n_i)
    begin
      nvm_nwords <= 4'h0;
      nvm_def_wr <= 7'h00;
      nvm_mode <= 1'b0;
    end
    else if (saving && copy_last)
    begin
      nvm_nwords <= nwords;
      nvm_def_wr <= def_wr;
      nvm_mode <= mode_new; // R15
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (start_exec)
    begin
      stack_ptr[0] <= cand_entry.start;
      stack_end[0] <= cand_entry.stop;
    end
    else if (elem_step)
    begin
      stack_ptr[top] <= cur_ptr + 7'h01;
      if (push)
      begin
        stack_ptr[sp[1:0]] <= ref_entry.start; // R07 R23
        stack_end[sp[1:0]] <= ref_entry.stop;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= word_xlat_pkg::S_RESTORE;
      def_phase <= word_xlat_pkg::D_NONE;
      mode_new <= 1'b0;
      nwords <= 4'h0;
      def_wr <= 7'h00;
      def_start <= 7'h00;
      def_key <= '0;
      cand <= 3'h0;
      opt_val <= 8'h00;
      opt_used <= 1'b0;
      sp <= 3'h0;
      list_idx <= 4'h0;
      cp_cnt <= 7'h00;
      clear_pend <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
      err <= 1'b0;
      err_code <= word_xlat_pkg::ERR_NONE;
    end
    else
    begin
      err <= 1'b0;
      if (out_valid && out_ready_i)
        out_valid <= 1'b0;
      clear_pend <= clear_req && saving;
      if (clear_take)
      begin
        // Working words are dropped and the saved set reloaded
        state <= word_xlat_pkg::S_RESTORE; // R14
        def_phase <= word_xlat_pkg::D_NONE;
        cp_cnt <= 7'h00;
        sp <= 3'h0;
      end
      else
      begin
        case (state)
          word_xlat_pkg::S_RESTORE, word_xlat_pkg::S_SAVE:
          begin
            cp_cnt <= cp_cnt + 7'h01;
            if (copy_last)
            begin
              state <= word_xlat_pkg::S_IDLE;
              if (restoring)
              begin
                nwords <= nvm_nwords;
                def_wr <= nvm_def_wr;
                mode_new <= nvm_mode; // R15
              end
            end
          end
          word_xlat_pkg::S_IDLE:
          begin
            if (idle_fire)
            begin
              case (def_phase)
                word_xlat_pkg::D_NONE:
                begin
                  case (tok_i.kind)
                    word_xlat_pkg::TK_NATIVE, word_xlat_pkg::TK_WILD:
                    begin
                      out_valid <= 1'b1; // R04 R06 R12
                      out_data <= {word_xlat_pkg::OUT_CHAR, 8'h00, tok_char};
                    end
                    word_xlat_pkg::TK_NAME:
                    begin
                      if (mode_new && hit) // R04 R06
                      begin
                        cand <= lookup[2:0];
                        state <= word_xlat_pkg::S_WAIT_OPT;
                      end
                    end
                    word_xlat_pkg::TK_ALIAS:
                    begin
                      mode_new <= 1'b1; // R05
                      def_phase <= word_xlat_pkg::D_NAME;
                      def_start <= def_wr;
                    end
                    word_xlat_pkg::TK_NEW:
                      mode_new <= 1'b1;
                    word_xlat_pkg::TK_OLD:
                      mode_new <= 1'b0; // R06
                    word_xlat_pkg::TK_SAVE:
                    begin
                      state <= word_xlat_pkg::S_SAVE; // R13
                      cp_cnt <= 7'h00;
                    end
                    word_xlat_pkg::TK_LIST, word_xlat_pkg::TK_WORD_LIST_QUERY:
                    begin
                      state <= word_xlat_pkg::S_LIST; // R16 R18
                      list_idx <= nwords;
                    end
                    word_xlat_pkg::TK_FORGET:
                    begin
                      nwords <= 4'h0; // R22
                      def_wr <= 7'h00;
                    end
                    word_xlat_pkg::TK_SEMI:
                    begin
                      err <= 1'b1;
                      err_code <= word_xlat_pkg::ERR_SYNTAX;
                    end
                    default:
                    begin
                    end
                  endcase
                end
                word_xlat_pkg::D_SKIP:
                begin
                  if ((tok_i.kind == word_xlat_pkg::TK_SEMI) || (tok_i.kind == word_xlat_pkg::TK_END))
                    def_phase <= word_xlat_pkg::D_NONE;
                end
                default:
                begin
                  // A failed definition rolls back so nothing it stored survives
                  if (store_elem)
                  begin
                    def_wr <= def_wr + 7'h01;
                    def_phase <= word_xlat_pkg::D_BODY;
                  end
                  else if (name_tok && !name_long && !hit && (nwords != word_xlat_pkg::WORDS_FULL))
                  begin
                    def_key <= tok_i.key;
                    def_phase <= word_xlat_pkg::D_BODY;
                  end
                  else if (commit)
                  begin
                    nwords <= nwords + 4'h1; // R08
                    def_phase <= word_xlat_pkg::D_NONE;
                  end
                  else if (body_tok && (tok_i.kind == word_xlat_pkg::TK_NEW))
                    def_phase <= word_xlat_pkg::D_REF; // R07
                  else
                  begin
                    err <= 1'b1;
                    def_wr <= def_start; // R20
                    def_phase <= (tok_i.kind == word_xlat_pkg::TK_SEMI) ? word_xlat_pkg::D_NONE :
                                 word_xlat_pkg::D_SKIP;
                    if (name_tok && name_long)
                      err_code <= word_xlat_pkg::ERR_NAME_LONG; // R19
                    else if (name_tok && hit)
                      err_code <= word_xlat_pkg::ERR_EXISTS; // R20
                    else if (mem_full || (name_tok && (nwords == word_xlat_pkg::WORDS_FULL)))
                      err_code <= word_xlat_pkg::ERR_MEM_FULL;
                    else if (ref_tok && (tok_i.kind == word_xlat_pkg::TK_NAME))
                      err_code <= word_xlat_pkg::ERR_UNKNOWN_REF;
                    else
                      err_code <= word_xlat_pkg::ERR_SYNTAX;
                  end
                end
              endcase
            end
          end
          word_xlat_pkg::S_WAIT_OPT:
          begin
            if (start_exec)
            begin
              opt_val <= is_number ? tok_char : word_xlat_pkg::OPTION_NONE; // R01 R03
              opt_used <= 1'b0;
              sp <= 3'h1;
              state <= word_xlat_pkg::S_EXEC;
            end
          end
          word_xlat_pkg::S_EXEC:
          begin
            if (exec_step && frame_done)
            begin
              sp <= sp - 3'h1;
              if (sp == 3'h1)
                state <= word_xlat_pkg::S_IDLE;
            end
            else if (push)
              sp <= sp + 3'h1;
            else if (elem_step && is_ref)
            begin
              err <= 1'b1;
              err_code <= word_xlat_pkg::ERR_NEST_DEPTH;
            end
            else if (elem_step)
            begin
              out_valid <= 1'b1; // R11 R12
              out_data <= {word_xlat_pkg::OUT_CHAR, 8'h00, cur_elem.data};
              if (first_wild)
              begin
                opt_used <= 1'b1;
                out_data <= {word_xlat_pkg::OUT_CHAR, 8'h00, opt_char(opt_val)}; // R09
              end
              else if (later_wild)
                out_data <= {word_xlat_pkg::OUT_CHAR, 8'h00, opt_char(word_xlat_pkg::OPTION_NONE)}; // R10
            end
          end
          word_xlat_pkg::S_LIST:
          begin
            if (list_step)
            begin
              out_valid <= 1'b1;
              if (list_idx == 4'h0)
              begin
                out_data <= {word_xlat_pkg::OUT_LIST_END, 16'h0000}; // R17
                state <= word_xlat_pkg::S_IDLE;
              end
              else
              begin
                out_data <= {word_xlat_pkg::OUT_LIST_NAME, newest_key}; // R16
                list_idx <= list_idx - 4'h1;
              end
            end
          end
          default:
            state <= word_xlat_pkg::S_IDLE;
        endcase
      end
    end
  end

  assign out_valid_o = out_valid;
  assign out_o = out_data;
  assign err_o = err;
  assign err_code_o = err_code;
  assign mode_new_o = mode_new;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  sequence save_req_s;
    plain_tok && (tok_i.kind == word_xlat_pkg::TK_SAVE) && !clear_take;
  endsequence

  sequence alias_req_s;
    plain_tok && (tok_i.kind == word_xlat_pkg::TK_ALIAS) && !clear_take;
  endsequence

  chk_first_wild_opt: assert property (first_wild |=> out_valid_o && opt_used &&
    (out_o.data[7:0] == word_xlat_pkg::ASCII_ZERO + $past(opt_val))) // R01 R09
    else $error("first wild-card element did not carry the sent option");
  chk_missing_opt: assert property (start_exec && !is_number |=> opt_val == 8'h00 &&
    state == word_xlat_pkg::S_EXEC) // R03
    else $error("missing option did not default to zero");
  chk_later_wild: assert property (later_wild |=> out_o.data[7:0] == word_xlat_pkg::ASCII_ZERO) // R10
    else $error("later wild-card element was not given option zero");
  chk_alias_mode: assert property (alias_req_s |=> mode_new_o ##1 mode_new_o || !$stable(state)) // R05
    else $error("definition did not enable recognition");
  chk_old_ignores: assert property (plain_tok && !mode_new && tok_i.kind == word_xlat_pkg::TK_NAME &&
    !clear_take |=> state == word_xlat_pkg::S_IDLE) // R06
    else $error("user word acted on while recognition is off");
  chk_native_pass: assert property (plain_tok && tok_i.kind == word_xlat_pkg::TK_NATIVE && !clear_take
    |=> out_valid_o && out_o.data[7:0] == $past(tok_char)) // R04
    else $error("native character not passed through");
  chk_save_copy: assert property (save_req_s |-> ##65 (state == word_xlat_pkg::S_IDLE &&
    nvm_mode == mode_new && nvm_nwords == nwords)) // R13 R15
    else $error("save did not store words and mode");
  chk_clear_drop: assert property (dev_clear_i && !saving |=> state == word_xlat_pkg::S_RESTORE &&
    cp_cnt == 7'h00) // R14
    else $error("device clear did not reload the saved set");
  chk_list_newest: assert property (list_step && list_idx != 4'h0 |=> out_valid_o &&
    out_o.kind == word_xlat_pkg::OUT_LIST_NAME && out_o.data == $past(newest_key)) // R16
    else $error("listing not newest first");
  chk_list_empty: assert property (plain_tok && tok_i.kind == word_xlat_pkg::TK_LIST && nwords == 4'h0 &&
    !clear_take |=> state == word_xlat_pkg::S_LIST && list_idx == 4'h0) // R17
    else $error("empty listing would return entries");
  chk_name_long: assert property (name_tok && name_long && !clear_take |=> err_o &&
    err_code_o == word_xlat_pkg::ERR_NAME_LONG) // R19
    else $error("over-long name not rejected");
  chk_redefine: assert property (name_tok && hit && !name_long && !clear_take |=> err_o &&
    err_code_o == word_xlat_pkg::ERR_EXISTS && $stable(nwords)) // R20
    else $error("existing word was redefined");
  chk_forget_all: assert property (plain_tok && tok_i.kind == word_xlat_pkg::TK_FORGET && !clear_take
    |=> nwords == 4'h0 && $stable(nvm_nwords)) // R22
    else $error("purge left words or touched the saved copy");

endmodule : word_xlat
`default_nettype wire

// ---- design/word_xlat_pkg.sv ----
// Purpose: Shared types and constants for the user word translator.
// Assumes: An upstream tokenizer splits bus strings into tokens on the same clock.
// Notes: Names are carried as a key plus their character count.
// Notes on behaviour
// R01: A wild-card element takes the option number sent after the word.
// R02: Host separates a wild-card word from its option number by a space.
// R03: A wild-card word sent without an option runs with option zero.
// R04: Enabled mode accepts user words and native commands alike.
// R05: A definition string switches recognition on by itself.
// R06: Disabled mode ignores user words and passes only native commands.
// R07: Recognition keyword inside a definition marks a reference; execution runs its commands.
// R08: Referenced words remain defined and usable on their own.
// R09: Only the first wild-card element reached gets the sent option.
// R10: Every later wild-card element in a combined word gets option zero.
// R11: Definitions may mix references with literal native command characters.
// R12: One string may mix user words, options and native commands; all run.
// R13: Save copies all current words to nonvolatile storage for power-up.
// R14: Unsaved words are lost on power-off, reset, device clears and default restore.
// R15: Save also stores the recognition mode; power-up restores it.
// R16: Listing outputs the working words newest definition first.
// R17: Listing with no words returns no word entries.
// R18: The word-list query gives the same listing.
// R19: Names longer than thirty-one characters are rejected.
// R20: Redefining an existing word fails and keeps the old definition.
// R21: Host ends each definition with one space and the terminator.
// R22: Purge deletes all working words and leaves the saved copy alone.
// R23: Definitions stay unexpanded; references resolve recursively when executed.
package word_xlat_pkg;

  localparam int NUM_WORDS = 8;
  localparam int DEF_DEPTH = 64;
  localparam int STACK_DEPTH = 4;
  localparam int MAX_NAME_LEN = 31;
  localparam int KEY_W = 16;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] OPTION_NONE = 8'h00;

  typedef logic [2:0] word_idx_t;
  typedef logic [3:0] count_t;
  typedef logic [6:0] def_ptr_t;
  typedef logic [2:0] sp_t;
  typedef logic [1:0] stack_idx_t;

  localparam count_t WORDS_FULL = 4'h8;
  localparam def_ptr_t DEF_FULL = 7'h40;
  localparam def_ptr_t COPY_LAST = 7'h3f;
  localparam sp_t STACK_FULL = 3'h4;

  typedef enum logic [3:0] {TK_NATIVE, TK_WILD, TK_NAME, TK_NUMBER, TK_ALIAS, TK_SEMI, TK_NEW, TK_OLD,
    TK_SAVE, TK_LIST, TK_FORGET, TK_WORD_LIST_QUERY, TK_END} tok_kind_t;

  typedef struct packed {
    tok_kind_t kind;
    logic [5:0] len;
    logic [KEY_W-1:0] key;
    logic [7:0] value;
  } tok_t;

  typedef enum logic [1:0] {EL_LIT, EL_WILD, EL_REF} elem_kind_t;

  typedef struct packed {
    elem_kind_t kind;
    logic [7:0] data;
  } elem_t;

  typedef struct packed {
    logic [KEY_W-1:0] key;
    def_ptr_t start;
    def_ptr_t stop;
  } entry_t;

  typedef enum logic [1:0] {OUT_CHAR, OUT_LIST_NAME, OUT_LIST_END} out_kind_t;

  typedef struct packed {
    out_kind_t kind;
    logic [KEY_W-1:0] data;
  } out_t;

  typedef enum logic [2:0] {ERR_NONE, ERR_MEM_FULL, ERR_NAME_LONG, ERR_EXISTS, ERR_UNKNOWN_REF,
    ERR_NEST_DEPTH, ERR_SYNTAX} err_code_t;

  typedef enum logic [2:0] {S_RESTORE, S_IDLE, S_WAIT_OPT, S_EXEC, S_LIST, S_SAVE} state_t;
  typedef enum logic [2:0] {D_NONE, D_NAME, D_BODY, D_REF, D_SKIP} def_phase_t;

endpackage : word_xlat_pkg

// ---- verification/macro_word_command_translator_tb.sv ----
// Purpose: Self-checking bench for the user word translator.
// Assumes: A token is held until an edge takes it with ready high.
// Notes: Keys stand for names; a name is 4 characters unless a test says more.
`timescale 1ns/1ns
`default_nettype none
module macro_word_command_translator_tb;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, nvm_erase_n_i = 1'b0, dev_clear_i = 1'b0, tok_valid_i = 1'b0;
  logic tok_ready_o, out_valid_o, out_ready_i, err_o, mode_new_o;
  word_xlat_pkg::tok_t tok_i = '0;
  word_xlat_pkg::out_t out_o;
  word_xlat_pkg::err_code_t err_code_o;
  int num_errors = 0, n_tests = 0, n_err = 0;
  always #5 mclk_i = ~mclk_i;
  // Error pulse stands one cycle; counted mid-cycle so each pulse counts once
  always @(negedge mclk_i) if (err_o === 1'b1) n_err++;
  word_xlat u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .nvm_erase_n_i(nvm_erase_n_i),
    .dev_clear_i(dev_clear_i), .tok_valid_i(tok_valid_i), .tok_i(tok_i), .tok_ready_o(tok_ready_o),
    .out_valid_o(out_valid_o), .out_o(out_o), .out_ready_i(out_ready_i), .err_o(err_o),
    .err_code_o(err_code_o), .mode_new_o(mode_new_o));
  out_sink u_sink (.mclk_i(mclk_i), .valid_i(out_valid_o), .data_i(out_o), .ready_o(out_ready_i));
  task end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task chk(string what, logic [17:0] seen, logic [17:0] want);
    n_tests++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : chk
  // Ready is combinational on state, token kind and output stall, not on valid, so the mid-cycle value is what the edge takes
  task send(word_xlat_pkg::tok_kind_t k, logic [15:0] key = 0, logic [7:0] v = 0, logic [5:0] n = 6'h04);
    tok_valid_i <= 1'b1;
    tok_i <= '{k, n, key, v};
    do @(negedge mclk_i); while (tok_ready_o !== 1'b1);
    @(posedge mclk_i);
  endtask : send
  task define_word(logic [15:0] key, logic [5:0] n = 6'h04);
    send(word_xlat_pkg::TK_ALIAS);
    send(word_xlat_pkg::TK_NAME, key, 0, n);
  endtask : define_word
  task run(logic [15:0] key, bit opt, logic [7:0] v);
    send(word_xlat_pkg::TK_NAME, key);
    if (opt) send(word_xlat_pkg::TK_NUMBER, 0, v);
  endtask : run
  task fin(int n);
    send(word_xlat_pkg::TK_END);
    tok_valid_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk("out count", 18'(u_sink.seen.size()), 18'(n));
  endtask : fin
  task exp(word_xlat_pkg::out_kind_t k, logic [15:0] d);
    if (u_sink.seen.size() > 0) chk("out", u_sink.seen.pop_front(), {k, d});
  endtask : exp
  task exp_str(string s);
    foreach (s[i]) exp(word_xlat_pkg::OUT_CHAR, {8'h00, s[i]});
  endtask : exp_str
  task t_wild;
    define_word(16'h0a01);
    send(word_xlat_pkg::TK_NATIVE, 0, "F");
    send(word_xlat_pkg::TK_WILD);
    send(word_xlat_pkg::TK_NATIVE, 0, "X");
    send(word_xlat_pkg::TK_SEMI);
    fin(0);
    chk("mode", mode_new_o, 1);
    run(16'h0a01, 1, 8'h06);
    fin(3);
    exp_str("F6X");
    run(16'h0a01, 0, 0);
    fin(3);
    exp_str("F0X");
    send(word_xlat_pkg::TK_SAVE);
  endtask : t_wild
  task t_combo;
    define_word(16'h0a02);
    for (int i = 0; i < 2; i++)
    begin
      send(word_xlat_pkg::TK_NEW);
      send(word_xlat_pkg::TK_NAME, 16'h0a01);
    end
    send(word_xlat_pkg::TK_NATIVE, 0, "Z");
    send(word_xlat_pkg::TK_SEMI);
    run(16'h0a02, 1, 8'h05);
    fin(7);
    exp_str("F5XF0XZ");
    run(16'h0a01, 1, 8'h02);
    send(word_xlat_pkg::TK_NATIVE, 0, "Q");
    fin(4);
    exp_str("F2XQ");
  endtask : t_combo
  task t_list(word_xlat_pkg::tok_kind_t k);
    send(k);
    fin(3);
    exp(word_xlat_pkg::OUT_LIST_NAME, 16'h0a02);
    exp(word_xlat_pkg::OUT_LIST_NAME, 16'h0a01);
    exp(word_xlat_pkg::OUT_LIST_END, 0);
  endtask : t_list
  task t_clear;
    send(word_xlat_pkg::TK_OLD);
    fin(0);
    chk("mode", mode_new_o, 0);
    dev_clear_i <= 1'b1;
    @(posedge mclk_i);
    dev_clear_i <= 1'b0;
    send(word_xlat_pkg::TK_LIST);
    fin(2);
    exp(word_xlat_pkg::OUT_LIST_NAME, 16'h0a01);
    exp(word_xlat_pkg::OUT_LIST_END, 0);
    chk("mode", mode_new_o, 1);
  endtask : t_clear
  task t_err;
    for (int i = 0; i < 2; i++)
    begin
      define_word(i ? 16'h0a03 : 16'h0a01, i ? 6'h20 : 6'h04);
      send(word_xlat_pkg::TK_NATIVE, 0, "Y");
      send(word_xlat_pkg::TK_SEMI);
      fin(0);
      chk("code", err_code_o, i ? word_xlat_pkg::ERR_NAME_LONG : word_xlat_pkg::ERR_EXISTS);
    end
    run(16'h0a03, 0, 0);
    run(16'h0a01, 0, 0);
    fin(3);
    exp_str("F0X");
    chk("error pulses", 18'(n_err), 18'h00002);
  endtask : t_err
  task t_old;
    send(word_xlat_pkg::TK_OLD);
    run(16'h0a01, 0, 0);
    send(word_xlat_pkg::TK_NATIVE, 0, "A");
    fin(1);
    exp_str("A");
    send(word_xlat_pkg::TK_FORGET);
    send(word_xlat_pkg::TK_LIST);
    fin(1);
    exp(word_xlat_pkg::OUT_LIST_END, 0);
    send(word_xlat_pkg::TK_SEMI);
    send(word_xlat_pkg::TK_NEW);
    fin(0);
    chk("code", err_code_o, word_xlat_pkg::ERR_SYNTAX);
    chk("mode", mode_new_o, 1);
  endtask : t_old
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    nvm_erase_n_i <= 1'b1;
    t_wild;
    t_combo;
    t_list(word_xlat_pkg::TK_LIST);
    t_list(word_xlat_pkg::TK_WORD_LIST_QUERY);
    t_clear;
    t_err;
    t_old;
    end_of_test;
  end
endmodule : macro_word_command_translator_tb
`default_nettype wire

// ---- verification/out_sink.sv ----
// Purpose: Command parser model that drains translator output.
// Assumes: Output is registered and changes at rising edges only.
// Notes: Ready stalls every other cycle, so output must hold.
`timescale 1ns/1ns
`default_nettype none
module out_sink (
  input wire logic mclk_i,
  input wire logic valid_i,
  input wire word_xlat_pkg::out_t data_i,
  output logic ready_o
);
  word_xlat_pkg::out_t seen[$];
  // One driver only; the first edge turns the unknown start into high
  always @(posedge mclk_i) ready_o <= (ready_o !== 1'b1);
  // Mid-cycle values are the ones the next edge takes
  always @(negedge mclk_i) if (valid_i === 1'b1 && ready_o) seen.push_back(data_i);
endmodule : out_sink
`default_nettype wire
